/* File: verilog/nvp_ctrl.sv */
// security, page, key and protection control for flash and eeprom
`timescale 1ns/100ps

// Operation
// - key match cannot unlock while the key-enable option bit is zero
// - eight ascending key bytes matching stored key unlock until next reset
// - key bytes written by background debug never count
// - option bit 6 disables vector redirection when set
// - option bit 5 selects split 4-byte or whole 8-byte eeprom sectors
// - lock code reports unsecured only for value 1:0
// - while secure, debug accesses to memories are refused
// - lock code becomes 1:0 after key match or whole-flash blank pass
// - config bit 6 picks eeprom foreground page; other page inaccessible
// - config bit 5 makes key window writes key bytes, else command launch
// - protection register reloads from stored byte at every reset
// - protection always readable; firmware writes only keep or grow it
// - program or erase at protected address refused, violation flag set
// - mass erase refused while any sector is protected
// - background debug writes alter protection directly
// - eeprom guard field decodes to none, 0x17F0, 0x17E0 or 0x17C0 up
// - flash guard field steps 1.5K per code down; 0x18 and below all
// - options register loads from stored byte at reset only
// - violation flag cleared by writing one, unchanged by zero
module nvp_ctrl
  import nvp_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pdebug,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // nonvolatile contents seen at reset
  input wire logic [7:0] stored_options_byte,
  input wire logic [7:0] stored_protection_byte,
  input wire logic [63:0] stored_unlock_key,
  // memory access requests
  input wire nvp_mem_req_t mem_req,
  output logic mem_deny,
  // program and erase commands
  input wire nvp_cmd_req_t cmd_req,
  input wire logic blank_all_pass,
  output logic cmd_grant,
  output logic cmd_refuse,
  output logic flash_launch,
  // configuration outputs
  output logic secure,
  output logic vector_redirect_disable,
  output logic eeprom_sector_mode,
  output logic eeprom_page_select
);
  // ****************************************************************
  // state
  // ****************************************************************
  localparam nvp_state_t STATE_RESET = '{
    loaded: 1'b0, options: 8'h00, cfg: CFG_RESET, protect: 8'hFF, key: 64'h0000_0000_0000_0000,
    guard_viol: 1'b0, key_idx: 3'h0, key_ok: 1'b1, cmd_grant: 1'b0, cmd_refuse: 1'b0,
    flash_launch: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0};

  nvp_state_t state_reg;
  nvp_state_t state_next;

  logic setup_phase;
  logic access_phase;
  logic addr_mapped;
  logic [1:0] eeprom_guard_select;
  logic [5:0] flash_guard_select;
  logic [16:0] flash_span;
  logic [16:0] flash_start;
  logic [15:0] ee_start;
  logic flash_guarded;
  logic ee_guarded;
  logic any_guarded;
  logic cmd_hits_guard;
  logic key_window_hit;
  logic key_byte_write;
  logic key_byte_match;
  logic [7:0] new_prot;
  logic prot_grows;

  // ****************************************************************
  // guard decoding
  // ****************************************************************
  assign eeprom_guard_select = state_reg.protect[7:6];
  assign flash_guard_select = state_reg.protect[5:0];
  assign flash_span = 17'(FPS_NONE - flash_guard_select) * FLASH_STEP;

  always_comb begin
    // codes at or below the all-protect threshold guard the whole space
    if (flash_guard_select <= FPS_ALL_MAX || flash_span >= FLASH_TOP) begin
      flash_start = 17'h0_0000;
    end else begin
      flash_start = FLASH_TOP - flash_span;
    end
    unique case (eeprom_guard_select)
      EPS_SMALL: ee_start = EE_START_SMALL;
      EPS_MID: ee_start = EE_START_MID;
      default: ee_start = EE_START_ALL;
    endcase
  end

  assign flash_guarded = (flash_guard_select != FPS_NONE) && ({1'b0, cmd_req.addr} >= flash_start);
  assign ee_guarded = (eeprom_guard_select != EPS_NONE) && (cmd_req.addr >= ee_start) && (cmd_req.addr <= EE_END);
  assign any_guarded = (flash_guard_select != FPS_NONE) || (eeprom_guard_select != EPS_NONE);
  assign cmd_hits_guard = (cmd_req.code == NVP_CMD_MASS_ERASE) ? any_guarded
    : (flash_guarded || ee_guarded);

  // ****************************************************************
  // key window
  // ****************************************************************
  assign key_window_hit = mem_req.valid && mem_req.write && (mem_req.addr[15:3] == KEY_WINDOW_BASE[15:3]);
  // debug writes and locked-off key enable never reach the comparator
  assign key_byte_write = key_window_hit && !mem_req.debug && secure
    && state_reg.options[OPT_KEY_EN_BIT] && state_reg.cfg[CFG_KEY_CAPTURE_BIT];
  assign key_byte_match = (mem_req.addr[2:0] == state_reg.key_idx)
    && (mem_req.data == state_reg.key[{state_reg.key_idx, 3'h0} +: 8]);

  // ****************************************************************
  // protection write check
  // ****************************************************************
  assign new_prot = pwdata[7:0];
  // lower codes guard more, so each field may only stay or fall
  assign prot_grows = (new_prot[7:6] <= eeprom_guard_select) && (new_prot[5:0] <= flash_guard_select);

  // ****************************************************************
  // apb decode
  // ****************************************************************
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign addr_mapped = (paddr == OFF_OPTIONS) || (paddr == OFF_CONFIG)
    || (paddr == OFF_PROTECT) || (paddr == OFF_STATUS);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.cmd_grant = 1'b0;
    state_next.cmd_refuse = 1'b0;
    state_next.flash_launch = 1'b0;

    // straps are caught on the first edge after reset release
    if (!state_reg.loaded) begin
      state_next.loaded = 1'b1;
      state_next.options = stored_options_byte;
      state_next.protect = stored_protection_byte;
      state_next.key = stored_unlock_key;
    end else begin
      // register writes take effect at the access phase
      if (access_phase && pwrite) begin
        unique case (paddr)
          OFF_CONFIG: state_next.cfg = new_prot & CFG_WRITE_MASK;
          OFF_PROTECT: begin
            if (pdebug || prot_grows) begin
              state_next.protect = new_prot;
            end
          end
          default: ; // options writes are dropped
        endcase
      end
      if (access_phase && pwrite && paddr == OFF_STATUS && pwdata[STAT_GUARD_VIOL_BIT]) begin
        state_next.guard_viol = 1'b0;
      end

      // key comparison, ascending byte order
      if (key_byte_write) begin
        if (state_reg.key_idx == KEY_LAST_INDEX) begin
          if (state_reg.key_ok && key_byte_match) begin
            state_next.options[1:0] = LOCK_OPEN;
          end
          state_next.key_idx = 3'h0;
          state_next.key_ok = 1'b1;
        end else begin
          state_next.key_idx = state_reg.key_idx + 3'h1;
          state_next.key_ok = state_reg.key_ok && key_byte_match;
        end
      end

      if (blank_all_pass) begin
        state_next.options[1:0] = LOCK_OPEN;
      end

      // key window writes launch a command when capture is off
      if (key_window_hit && !state_reg.cfg[CFG_KEY_CAPTURE_BIT] && !mem_deny) begin
        state_next.flash_launch = 1'b1;
      end

      // program and erase commands against the guard ranges
      if (cmd_req.valid && cmd_req.code != NVP_CMD_BLANK_CHECK) begin
        if (cmd_hits_guard) begin
          state_next.cmd_refuse = 1'b1;
          state_next.guard_viol = 1'b1; // set wins over clear
        end else begin
          state_next.cmd_grant = 1'b1;
        end
      end else if (cmd_req.valid) begin
        state_next.cmd_grant = 1'b1;
      end
    end

    // read data is captured at setup so the access phase needs no wait
    if (setup_phase) begin
      state_next.pslverr = !addr_mapped;
      unique case (paddr)
        OFF_OPTIONS: state_next.prdata = {24'h00_0000, state_reg.options};
        OFF_CONFIG: state_next.prdata = {24'h00_0000, state_reg.cfg};
        OFF_PROTECT: state_next.prdata = {24'h00_0000, state_reg.protect};
        OFF_STATUS: state_next.prdata = 32'(state_reg.guard_viol) << STAT_GUARD_VIOL_BIT;
        default: state_next.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata = state_reg.prdata;
  assign pready = 1'b1;
  assign pslverr = access_phase && state_reg.pslverr;
  // until the straps land the part counts as secure
  assign secure = !state_reg.loaded || (state_reg.options[1:0] != LOCK_OPEN);
  assign mem_deny = mem_req.valid && mem_req.debug && secure;
  assign cmd_grant = state_reg.cmd_grant;
  assign cmd_refuse = state_reg.cmd_refuse;
  assign flash_launch = state_reg.flash_launch;
  assign vector_redirect_disable = state_reg.options[OPT_REDIR_DIS_BIT];
  assign eeprom_sector_mode = state_reg.options[OPT_SECTOR_MODE_BIT];
  assign eeprom_page_select = state_reg.cfg[CFG_PAGE_SEL_BIT];

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  no_key_unlock_a: assert property (
    secure && !state_reg.options[OPT_KEY_EN_BIT] && !blank_all_pass && state_reg.loaded |=> secure)
    else $error("unlocked with key enable clear");

  debug_key_ignored_a: assert property (
    key_window_hit && mem_req.debug && state_reg.loaded |=> state_reg.key_idx == $past(state_reg.key_idx))
    else $error("debug write advanced key index");

  lock_code_a: assert property (
    state_reg.loaded |-> secure == (state_reg.options[1:0] != LOCK_OPEN))
    else $error("lock code decode wrong");

  debug_deny_a: assert property (
    mem_req.valid && mem_req.debug && secure |-> mem_deny)
    else $error("debug access allowed while secure");

  blank_unlock_a: assert property (
    blank_all_pass && state_reg.loaded |=> !secure)
    else $error("blank pass did not unlock");

  reset_load_a: assert property (
    !state_reg.loaded ##1 state_reg.loaded |-> state_reg.protect == $past(stored_protection_byte)
      && state_reg.options == $past(stored_options_byte))
    else $error("straps not loaded");

  prot_no_shrink_a: assert property (
    state_reg.loaded && access_phase && pwrite && paddr == OFF_PROTECT && !pdebug && !prot_grows
      && !blank_all_pass |=> $stable(state_reg.protect))
    else $error("protection shrank");

  viol_set_a: assert property (
    state_reg.loaded && cmd_req.valid && cmd_req.code != NVP_CMD_BLANK_CHECK && cmd_hits_guard
      |=> cmd_refuse && !cmd_grant && state_reg.guard_viol)
    else $error("guarded command not refused");

  mass_refuse_a: assert property (
    state_reg.loaded && cmd_req.valid && cmd_req.code == NVP_CMD_MASS_ERASE && any_guarded |=> cmd_refuse)
    else $error("mass erase let through");

  viol_clear_a: assert property (
    state_reg.guard_viol && !(cmd_req.valid && cmd_hits_guard) && !(access_phase && pwrite
      && paddr == OFF_STATUS && pwdata[STAT_GUARD_VIOL_BIT]) |=> state_reg.guard_viol)
    else $error("violation flag lost");

  options_ro_a: assert property (
    state_reg.loaded && !blank_all_pass && !key_byte_write |=> $stable(state_reg.options))
    else $error("options register changed");

  key_unlock_c: cover property (key_byte_write && state_reg.key_idx == KEY_LAST_INDEX ##1 !secure);
  refuse_c: cover property (cmd_refuse ##[1:4] access_phase && pwrite && paddr == OFF_STATUS);
  prot_grow_c: cover property (access_phase && pwrite && paddr == OFF_PROTECT && prot_grows && !pdebug);
endmodule

/* File: verilog/nvp_pkg.sv */
// package for the nonvolatile-memory security and protection configuration block
package nvp_pkg;
  // ****************************************************************
  // register map (byte offsets on the apb bus)
  // ****************************************************************
  localparam logic [7:0] OFF_OPTIONS = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_PROTECT = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int OPT_KEY_EN_BIT = 7;
  localparam int OPT_REDIR_DIS_BIT = 6;
  localparam int OPT_SECTOR_MODE_BIT = 5;
  localparam int CFG_PAGE_SEL_BIT = 6;
  localparam int CFG_KEY_CAPTURE_BIT = 5;
  localparam int STAT_GUARD_VIOL_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hE0;
  localparam logic [1:0] LOCK_OPEN = 2'h2;

  // ****************************************************************
  // key window and guard decoding
  // ****************************************************************
  localparam logic [15:0] KEY_WINDOW_BASE = 16'hFFB0;
  localparam logic [2:0] KEY_LAST_INDEX = 3'h7;
  localparam logic [5:0] FPS_NONE = 6'h3F;
  localparam logic [5:0] FPS_ALL_MAX = 6'h18;
  localparam logic [16:0] FLASH_TOP = 17'h1_0000;
  localparam logic [16:0] FLASH_STEP = 17'h0_0600;
  localparam logic [1:0] EPS_NONE = 2'h3;
  localparam logic [1:0] EPS_SMALL = 2'h2;
  localparam logic [1:0] EPS_MID = 2'h1;
  localparam logic [15:0] EE_START_SMALL = 16'h17F0;
  localparam logic [15:0] EE_START_MID = 16'h17E0;
  localparam logic [15:0] EE_START_ALL = 16'h17C0;
  localparam logic [15:0] EE_END = 16'h17FF;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    NVP_CMD_PROGRAM = 2'h0,
    NVP_CMD_SECTOR_ERASE = 2'h1,
    NVP_CMD_MASS_ERASE = 2'h2,
    NVP_CMD_BLANK_CHECK = 2'h3
  } nvp_cmd_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic debug;
    logic [15:0] addr;
    logic [7:0] data;
  } nvp_mem_req_t;

  typedef struct packed {
    logic valid;
    nvp_cmd_t code;
    logic [15:0] addr;
  } nvp_cmd_req_t;

  typedef struct packed {
    logic loaded;
    logic [7:0] options;
    logic [7:0] cfg;
    logic [7:0] protect;
    logic [63:0] key;
    logic guard_viol;
    logic [2:0] key_idx;
    logic key_ok;
    logic cmd_grant;
    logic cmd_refuse;
    logic flash_launch;
    logic [31:0] prdata;
    logic pslverr;
  } nvp_state_t;
endpackage

/* File: testbench/tb_nvm_security_protection_config.sv */
// self-checking testbench for the nvm security and protection control block
`timescale 1ns/100ps
module tb_nvm_security_protection_config;
  import nvp_pkg::*;
  typedef struct packed {
    nvp_cmd_t code;
    logic [15:0] addr;
    logic refuse;
  } nvp_row_t;
  // key value is arbitrary
  localparam logic [63:0] KEY = 64'h0123_4567_89AB_CDEF;
  logic pclk, presetn, psel, penable, pwrite, pdebug, pready, pslverr, err;
  logic [7:0] paddr, opt_strap, prot_strap;
  logic [31:0] pwdata, prdata, rd;
  nvp_mem_req_t mem_req;
  nvp_cmd_req_t cmd_req;
  logic blank_all_pass, mem_deny, cmd_grant, cmd_refuse, flash_launch;
  logic secure, vector_redirect_disable, eeprom_sector_mode, eeprom_page_select;
  int error_cnt, checks_done, cycles;
  nvp_row_t rows [8];

  nvp_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pdebug(pdebug), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stored_options_byte(opt_strap), .stored_protection_byte(prot_strap), .stored_unlock_key(KEY),
    .mem_req(mem_req), .mem_deny(mem_deny), .cmd_req(cmd_req), .blank_all_pass(blank_all_pass),
    .cmd_grant(cmd_grant), .cmd_refuse(cmd_refuse), .flash_launch(flash_launch), .secure(secure),
    .vector_redirect_disable(vector_redirect_disable), .eeprom_sector_mode(eeprom_sector_mode),
    .eeprom_page_select(eeprom_page_select));

  // ****************************************************************
  // clock, timeout and report
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ****************************************************************
  // drivers and comparison
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask

  task automatic b(input string n, input logic e, input logic g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic dbg);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pdebug <= dbg;
    @(posedge pclk);
    penable <= 1'b1;
    // this wait ends once pready is seen high, or else at the bench timeout
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    b("pready", 1'b1, pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // step past the write edge so callers see the registered result
    #1;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0000_0000, 1'b0);
    chk(n, e, rd);
  endtask

  task automatic cmd(input nvp_row_t r);
    @(posedge pclk);
    cmd_req <= '{1'b1, r.code, r.addr};
    @(posedge pclk);
    cmd_req.valid <= 1'b0;
    #1;
    b("cmd_refuse", r.refuse, cmd_refuse);
    b("cmd_grant", !r.refuse, cmd_grant);
  endtask

  task automatic key(input logic [63:0] k, input logic dbg);
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      mem_req <= '{1'b1, 1'b1, dbg, KEY_WINDOW_BASE + 16'(i), k[8*i +: 8]};
    end
    @(posedge pclk);
    mem_req <= '0;
    @(posedge pclk);
    #1;
  endtask

  task automatic deny(input logic e);
    @(posedge pclk);
    mem_req <= '{1'b1, 1'b0, 1'b1, 16'h1000, 8'h00};
    #1;
    b("mem_deny", e, mem_deny);
    @(posedge pclk);
    mem_req <= '0;
  endtask

  task automatic do_reset(input logic [7:0] o, input logic [7:0] p);
    presetn <= 1'b0;
    opt_strap <= o;
    prot_strap <= p;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, pdebug, blank_all_pass} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    mem_req = '0;
    cmd_req = '0;
    opt_strap = 8'h00;
    prot_strap = 8'h00;
    rows = '{'{NVP_CMD_PROGRAM, 16'hF9FF, 1'b0}, '{NVP_CMD_PROGRAM, 16'hFA00, 1'b1},
      '{NVP_CMD_SECTOR_ERASE, 16'hFFFF, 1'b1}, '{NVP_CMD_PROGRAM, 16'h17EF, 1'b0},
      '{NVP_CMD_SECTOR_ERASE, 16'h17F0, 1'b1}, '{NVP_CMD_MASS_ERASE, 16'h0000, 1'b1},
      '{NVP_CMD_BLANK_CHECK, 16'h0000, 1'b0}, '{NVP_CMD_SECTOR_ERASE, 16'h8000, 1'b0}};
    do_reset(8'hE3, 8'hBE);
    rdchk(OFF_OPTIONS, 32'h0000_00E3, "options");
    apb(1'b1, OFF_OPTIONS, 32'h0000_0000, 1'b0);
    rdchk(OFF_OPTIONS, 32'h0000_00E3, "options_wr");
    b("redirect_dis", 1'b1, vector_redirect_disable);
    b("sector_mode", 1'b1, eeprom_sector_mode);
    b("secure", 1'b1, secure);
    rdchk(OFF_PROTECT, 32'h0000_00BE, "protect");
    rdchk(OFF_CONFIG, {24'h0, CFG_RESET}, "config");
    for (int i = 0; i < 8; i++) begin
      cmd(rows[i]);
    end
    rdchk(OFF_STATUS, 32'h0000_0020, "status");
    apb(1'b1, OFF_STATUS, 32'h0000_0000, 1'b0);
    rdchk(OFF_STATUS, 32'h0000_0020, "status_w0");
    apb(1'b1, OFF_STATUS, 32'h0000_0020, 1'b0);
    rdchk(OFF_STATUS, 32'h0000_0000, "status_w1");
    apb(1'b1, OFF_PROTECT, 32'h0000_00FF, 1'b0);
    rdchk(OFF_PROTECT, 32'h0000_00BE, "prot_shrink");
    apb(1'b1, OFF_PROTECT, 32'h0000_007D, 1'b0);
    rdchk(OFF_PROTECT, 32'h0000_007D, "prot_grow");
    cmd('{NVP_CMD_PROGRAM, 16'hF400, 1'b1});
    cmd('{NVP_CMD_PROGRAM, 16'hF3FF, 1'b0});
    cmd('{NVP_CMD_PROGRAM, 16'h17E0, 1'b1});
    apb(1'b1, OFF_PROTECT, 32'h0000_00FF, 1'b1);
    rdchk(OFF_PROTECT, 32'h0000_00FF, "prot_debug");
    cmd('{NVP_CMD_MASS_ERASE, 16'h0000, 1'b0});
    apb(1'b1, OFF_PROTECT, 32'h0000_00C5, 1'b0);
    cmd('{NVP_CMD_PROGRAM, 16'h0000, 1'b1});
    // software keeps the reserved config bit at one
    apb(1'b1, OFF_CONFIG, 32'h0000_00C0, 1'b0);
    b("page_select", 1'b1, eeprom_page_select);
    @(posedge pclk);
    mem_req <= '{1'b1, 1'b1, 1'b0, KEY_WINDOW_BASE, 8'h55};
    @(posedge pclk);
    mem_req <= '0;
    #1;
    b("flash_launch", 1'b1, flash_launch);
    apb(1'b1, OFF_CONFIG, 32'h0000_00FF, 1'b0);
    rdchk(OFF_CONFIG, 32'h0000_00E0, "config_wr");
    deny(1'b1);
    key(KEY, 1'b1);
    b("secure_dbgkey", 1'b1, secure);
    key(KEY ^ 64'h0100_0000_0000_0000, 1'b0);
    b("secure_badkey", 1'b1, secure);
    key(KEY, 1'b0);
    b("secure_key", 1'b0, secure);
    rdchk(OFF_OPTIONS, 32'h0000_00E2, "lock_code");
    deny(1'b0);
    apb(1'b0, 8'h10, 32'h0000_0000, 1'b0);
    chk("unmapped_rd", 32'h0000_0000, rd);
    b("unmapped_err", 1'b1, err);
    do_reset(8'h03, 8'hBE);
    rdchk(OFF_PROTECT, 32'h0000_00BE, "prot_reload");
    b("secure_rst", 1'b1, secure);
    b("redirect_en", 1'b0, vector_redirect_disable);
    b("sector_split", 1'b0, eeprom_sector_mode);
    apb(1'b1, OFF_CONFIG, 32'h0000_00A0, 1'b0);
    b("page_zero", 1'b0, eeprom_page_select);
    key(KEY, 1'b0);
    b("secure_keyoff", 1'b1, secure);
    @(posedge pclk);
    blank_all_pass <= 1'b1;
    @(posedge pclk);
    blank_all_pass <= 1'b0;
    @(posedge pclk);
    #1;
    b("secure_blank", 1'b0, secure);
    do_reset(8'h02, 8'hFF);
    b("secure_open", 1'b0, secure);
    cmd('{NVP_CMD_MASS_ERASE, 16'h0000, 1'b0});
    stop_test();
  end
endmodule
